// ### shared/ssc_pkg.sv
package ssc_pkg;

    // Register map, byte addresses within the low address bits
    localparam int unsigned        ADDR_W    = 12;
    localparam logic [11:0]        CS_OFS    = 12'h000;
    localparam logic [11:0]        IMASK_OFS = 12'h004;

    // Field positions in the control/status byte
    localparam int unsigned        XFER_DONE_BIT = 7;
    localparam int unsigned        WRITE_COLLISION_FLAG_BIT      = 6;
    localparam int unsigned        MODE_FAULT_FLAG_BIT      = 5;
    localparam int unsigned        OVR_BIT       = 4;
    localparam int unsigned        BUSY_BIT      = 3;
    localparam int unsigned        SEL_BIT       = 2;
    localparam int unsigned        MASTER_ENABLE_BIT     = 1;
    localparam int unsigned        PEN_BIT       = 0;
    localparam int unsigned        FLAG_LSB      = 4;
    localparam int unsigned        NUM_FLAGS     = 4;

    // Index of each sticky flag in the flag vector (vector bit i is register bit 4+i)
    localparam int unsigned        FLG_OVR  = 0;
    localparam int unsigned        FLG_MODE_FAULT_FLAG = 1;
    localparam int unsigned        FLG_WRITE_COLLISION_FLAG = 2;
    localparam int unsigned        FLG_DONE = 3;

    // Synchronised pins
    localparam int unsigned        NUM_PINS     = 2;
    localparam int unsigned        PIN_NSS      = 0;
    localparam int unsigned        PIN_SCK      = 1;
    localparam logic [1:0]         PIN_SYNC_RST = 2'h1;

    // Reset values
    localparam logic               MASTER_ENABLE_RST = 1'h0;
    localparam logic               PEN_RST   = 1'h0;
    localparam logic [3:0]         MASK_RST  = 4'h0;
    localparam logic [3:0]         FLAG_RST  = 4'h0;

    // Serial frame length
    localparam int unsigned        BITS_PER_XFER = 8;

    // Bus encodings
    localparam logic [1:0]         HTRANS_NONSEQ = 2'h2;
    localparam logic               HRESP_OKAY    = 1'h0;

endpackage

// ### shared/ssc_sig_if.sv
`timescale 1ns/1ps
interface ssc_sig_if #(
    parameter int unsigned NF = 4,
    parameter int unsigned NS = 2
);
    logic [NF-1:0] set;
    logic [NF-1:0] clr;
    logic [NF-1:0] q;
    logic [NS-1:0] raw;
    logic [NS-1:0] synced;

    modport flag_side (input set, input clr, output q);
    modport sync_side (input raw, output synced);
    modport ctl       (output set, output clr, output raw, input q, input synced);
endinterface

// ### core/ssc_sync.sv
`timescale 1ns/1ps
module ssc_sync #(
    parameter int unsigned          NS      = 2,
    parameter logic [NS-1:0]        RST_VAL = '0
) (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // Pins in, synchronised levels out
    ssc_sig_if.sync_side            sig
);
    typedef struct packed {
        logic [NS-1:0] s1;
        logic [NS-1:0] s2;
    } ssc_sync_st_t;

    ssc_sync_st_t st_q;
    ssc_sync_st_t st_d;

    // First stage feeds only the second stage
    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = sig.raw;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_q <= '{s1: RST_VAL, s2: RST_VAL};
        else
            st_q <= st_d;
    end

    assign sig.synced = st_q.s2;
endmodule

// ### core/ssc_flag.sv
`timescale 1ns/1ps
module ssc_flag #(
    parameter int unsigned          IDX = 0
) (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // Set and clear strobes, flag out
    ssc_sig_if.flag_side            sig
);
    typedef struct packed {
        logic flag;
    } ssc_flag_st_t;

    ssc_flag_st_t st_q;
    ssc_flag_st_t st_d;

    // A set in the clearing cycle wins, so no event is lost
    always_comb
    begin
        st_d      = st_q;
        st_d.flag = sig.set[IDX] | (st_q.flag & ~sig.clr[IDX]);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_q <= '{flag: ssc_pkg::FLAG_RST[IDX]};
        else
            st_q <= st_d;
    end

    assign sig.q[IDX] = st_q.flag;
endmodule

// ### core/ssc_top.sv
// Function
// - At the end of each transfer the transfer-complete flag is set and only software clears it.
// - A data-register write during a transfer sets the write-collision flag in bit 6.
// - Slave select low while master mode is on sets the mode-fault flag in bit 5.
// - The last bit arriving while the receive buffer is unread sets the overrun flag in bit 4.
// - Bit 3 shows busy for the whole of a master transfer and drops when it ends.
// - Bit 2 reads one while the slave-select pin is low and zero while it is high.
// - Bit 1 at zero makes the port a slave and at one a master.
// - Bit 0 at zero keeps the port disabled and at one enables it.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ssc_top #(
    parameter int unsigned          XFER_BITS = ssc_pkg::BITS_PER_XFER
) (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp,
    // Serial pins, asynchronous
    input  wire logic               slave_select_n,
    input  wire logic               sck,
    // Shift engine, same clock
    input  wire logic               eng_dat_wr,
    input  wire logic               eng_xfer_done,
    input  wire logic               eng_rx_unread,
    output logic                    eng_load_ok,
    // Configuration and interrupt
    output logic                    master_enable,
    output logic                    port_enable,
    output logic                    port_irq
);
    localparam int unsigned CW = (XFER_BITS > 1) ? $clog2(XFER_BITS) : 1;
    localparam logic [CW-1:0] LAST_BIT = CW'(XFER_BITS - 1);

    typedef struct packed {
        logic                         pend;
        logic                         pend_wr;
        logic [ssc_pkg::ADDR_W-1:0]   pend_ofs;
        logic                         hreadyout;
        logic [31:0]                  hrdata;
        logic                         mst;
        logic                         pen;
        logic                         busy;
        logic                         sel;
        logic                         sck_prev;
        logic [CW-1:0]                bit_cnt;
        logic [3:0]                   mask;
        logic                         irq;
        logic                         load_ok;
    } ssc_top_st_t;

    ssc_top_st_t st_q;
    ssc_top_st_t st_d;

    ssc_sig_if #(.NF(ssc_pkg::NUM_FLAGS), .NS(ssc_pkg::NUM_PINS)) sig ();

    // Pin synchroniser
    ssc_sync #(
        .NS      (ssc_pkg::NUM_PINS),
        .RST_VAL (ssc_pkg::PIN_SYNC_RST)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sig     (sig.sync_side)
    );

    // Sticky flags
    for (genvar i = 0; i < ssc_pkg::NUM_FLAGS; i++)
    begin : g_flag
        ssc_flag #(
            .IDX     (i)
        ) u_flag (
            .hclk    (hclk),
            .hresetn (hresetn),
            .sig     (sig.flag_side)
        );
    end

    assign sig.raw[ssc_pkg::PIN_NSS] = slave_select_n;
    assign sig.raw[ssc_pkg::PIN_SCK] = sck;

    logic       nss_s;
    logic       sck_s;
    logic       bus_acc;
    logic       sck_rise;
    logic       slave_act;
    logic       slave_end;
    logic       mst_end;
    logic       in_prog;
    logic [3:0] set_v;
    logic [3:0] clr_v;

    assign nss_s     = sig.synced[ssc_pkg::PIN_NSS];
    assign sck_s     = sig.synced[ssc_pkg::PIN_SCK];
    assign bus_acc   = hsel & (htrans == ssc_pkg::HTRANS_NONSEQ) & hready;
    assign sck_rise  = sck_s & ~st_q.sck_prev;
    assign slave_act = st_q.pen & ~st_q.mst & ~nss_s;
    assign mst_end   = st_q.busy & eng_xfer_done;
    assign in_prog   = st_q.busy | (slave_act & (st_q.bit_cnt != '0));
    assign slave_end = slave_act & sck_rise & (st_q.bit_cnt == LAST_BIT);

    always_comb
    begin
        st_d          = st_q;
        st_d.load_ok  = 1'b0;
        st_d.sck_prev = sck_s;
        clr_v         = 4'h0;
        set_v         = 4'h0;

        // Bus: one wait state per transfer, so read data always comes from a register
        if (st_q.pend)
        begin
            st_d.pend      = 1'b0;
            st_d.hreadyout = 1'b1;
            if (st_q.pend_wr)
            begin
                if (st_q.pend_ofs == ssc_pkg::CS_OFS)
                begin
                    st_d.mst = hwdata[ssc_pkg::MASTER_ENABLE_BIT];
                    st_d.pen = hwdata[ssc_pkg::PEN_BIT];
                    clr_v    = hwdata[ssc_pkg::FLAG_LSB +: 4];
                end
                else if (st_q.pend_ofs == ssc_pkg::IMASK_OFS)
                begin
                    st_d.mask = hwdata[ssc_pkg::FLAG_LSB +: 4];
                end
            end
            else
            begin
                if (st_q.pend_ofs == ssc_pkg::CS_OFS)
                    st_d.hrdata = {24'h0, sig.q, st_q.busy, st_q.sel, st_q.mst, st_q.pen};
                else if (st_q.pend_ofs == ssc_pkg::IMASK_OFS)
                    st_d.hrdata = {24'h0, st_q.mask, 4'h0};
                else
                    st_d.hrdata = 32'h0;
            end
        end
        else if (bus_acc)
        begin
            st_d.pend      = 1'b1;
            st_d.pend_wr   = hwrite;
            st_d.pend_ofs  = haddr[ssc_pkg::ADDR_W-1:0];
            st_d.hreadyout = 1'b0;
        end

        // Slave frame: count link clock rising edges while selected
        if (!slave_act)
            st_d.bit_cnt = '0;
        else if (sck_rise)
            st_d.bit_cnt = slave_end ? '0 : st_q.bit_cnt + CW'(1);

        set_v[ssc_pkg::FLG_DONE] = slave_end | mst_end;
        set_v[ssc_pkg::FLG_OVR]  = (slave_end | mst_end) & eng_rx_unread;
        set_v[ssc_pkg::FLG_MODE_FAULT_FLAG] = ~nss_s & st_q.mst;
        set_v[ssc_pkg::FLG_WRITE_COLLISION_FLAG] = eng_dat_wr & in_prog;

        // A colliding write is dropped here so the shifter keeps its frame
        if (eng_dat_wr && st_q.pen && !in_prog)
        begin
            st_d.load_ok = 1'b1;
            if (st_q.mst)
                st_d.busy = 1'b1;
        end
        if (mst_end || !st_q.pen || !st_q.mst)
            st_d.busy = 1'b0;

        st_d.sel = ~nss_s;
        st_d.irq = |(sig.q & st_q.mask);
    end

    assign sig.set = set_v;
    assign sig.clr = clr_v;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q           <= '0;
            st_q.hreadyout <= 1'b1;
            st_q.mst       <= ssc_pkg::MASTER_ENABLE_RST;
            st_q.pen       <= ssc_pkg::PEN_RST;
            st_q.mask      <= ssc_pkg::MASK_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp <= ssc_pkg::HRESP_OKAY;
        else
            hresp <= ssc_pkg::HRESP_OKAY;
    end

    assign hreadyout     = st_q.hreadyout;
    assign hrdata        = st_q.hrdata;
    assign master_enable = st_q.mst;
    assign port_enable   = st_q.pen;
    assign port_irq      = st_q.irq;
    assign eng_load_ok   = st_q.load_ok;

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic cs_wr;
    assign cs_wr = st_q.pend & st_q.pend_wr & (st_q.pend_ofs == ssc_pkg::CS_OFS);

    sequence s_bus_accept;
        bus_acc && !st_q.pend;
    endsequence

    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    sequence s_colliding_write;
        eng_dat_wr && in_prog;
    endsequence

    sequence s_master_load;
        eng_dat_wr && st_q.pen && st_q.mst && !in_prog;
    endsequence

    a_bus_wait_state: assert property (s_bus_accept |=> s_one_wait)
        else $error("bus transfer did not take exactly one wait state");

    a_done_flag_set: assert property ((slave_end || mst_end)
        |=> sig.q[ssc_pkg::FLG_DONE])
        else $error("transfer end did not set the done flag");

    a_done_flag_hold: assert property (sig.q[ssc_pkg::FLG_DONE]
        && !(cs_wr && hwdata[ssc_pkg::XFER_DONE_BIT]) |=> sig.q[ssc_pkg::FLG_DONE])
        else $error("done flag dropped without a software clear");

    a_write_collision_flag_flag_set: assert property (s_colliding_write |=> sig.q[ssc_pkg::FLG_WRITE_COLLISION_FLAG])
        else $error("colliding write did not set the collision flag");

    a_mode_fault_flag_flag_set: assert property (!nss_s && st_q.mst |=> sig.q[ssc_pkg::FLG_MODE_FAULT_FLAG])
        else $error("mode fault not flagged");

    a_ovr_flag_set: assert property ((slave_end || mst_end) && eng_rx_unread
        |=> sig.q[ssc_pkg::FLG_OVR])
        else $error("overrun not flagged");

    a_busy_ends: assert property (mst_end |=> !st_q.busy)
        else $error("busy stayed high after master transfer end");

    a_busy_holds: assert property (st_q.busy && !eng_xfer_done && st_q.pen && st_q.mst
        |=> st_q.busy)
        else $error("busy dropped during master transfer");

    a_sel_follows: assert property (st_q.sel == !$past(nss_s))
        else $error("selected indicator does not follow slave select");

    a_busy_master_only: assert property ($rose(st_q.busy) |-> $past(st_q.mst))
        else $error("busy rose outside master mode");

    a_disabled_idle: assert property (!st_q.pen |=> !st_q.busy && !st_q.load_ok)
        else $error("disabled port started a transfer");

    a_collide_no_load: assert property (s_colliding_write |=> !st_q.load_ok)
        else $error("colliding write reached the shifter");

    a_irq_tracks: assert property ((|(sig.q & st_q.mask)) |=> port_irq)
        else $error("interrupt missing while an unmasked flag is set");

    a_irq_quiet: assert property (!(|(sig.q & st_q.mask)) |=> !port_irq)
        else $error("interrupt raised with no unmasked flag");

    a_hresp_okay: assert property (hresp == ssc_pkg::HRESP_OKAY)
        else $error("bus response was not OKAY");

    a_rdata_holds: assert property (!(st_q.pend && !st_q.pend_wr) |=> $stable(hrdata))
        else $error("read data changed outside a read data phase");

    // Each flag rises only on its own event and falls only on its own clear
    a_done_needs_end: assert property ($rose(sig.q[ssc_pkg::FLG_DONE])
        |-> $past(slave_end || mst_end))
        else $error("done flag set with no transfer end");

    a_done_cleared: assert property (cs_wr && hwdata[ssc_pkg::XFER_DONE_BIT]
        && !slave_end && !mst_end |=> !sig.q[ssc_pkg::FLG_DONE])
        else $error("software clear of the done flag had no effect");

    a_write_collision_flag_flag_hold: assert property (sig.q[ssc_pkg::FLG_WRITE_COLLISION_FLAG]
        && !(cs_wr && hwdata[ssc_pkg::WRITE_COLLISION_FLAG_BIT]) |=> sig.q[ssc_pkg::FLG_WRITE_COLLISION_FLAG])
        else $error("collision flag dropped without a software clear");

    a_write_collision_flag_needs_write: assert property ($rose(sig.q[ssc_pkg::FLG_WRITE_COLLISION_FLAG])
        |-> $past(eng_dat_wr && in_prog))
        else $error("collision flag set with no colliding write");

    a_mode_fault_flag_flag_hold: assert property (sig.q[ssc_pkg::FLG_MODE_FAULT_FLAG]
        && !(cs_wr && hwdata[ssc_pkg::MODE_FAULT_FLAG_BIT]) |=> sig.q[ssc_pkg::FLG_MODE_FAULT_FLAG])
        else $error("mode fault flag dropped without a software clear");

    a_mode_fault_flag_needs_fault: assert property ($rose(sig.q[ssc_pkg::FLG_MODE_FAULT_FLAG])
        |-> $past(!nss_s && st_q.mst))
        else $error("mode fault flag set with no fault");

    a_ovr_flag_hold: assert property (sig.q[ssc_pkg::FLG_OVR]
        && !(cs_wr && hwdata[ssc_pkg::OVR_BIT]) |=> sig.q[ssc_pkg::FLG_OVR])
        else $error("overrun flag dropped without a software clear");

    a_ovr_needs_unread: assert property ($rose(sig.q[ssc_pkg::FLG_OVR])
        |-> $past((slave_end || mst_end) && eng_rx_unread))
        else $error("overrun flag set with no unread data");

    a_busy_on_load: assert property (s_master_load |=> st_q.busy && st_q.load_ok)
        else $error("accepted master load did not start a transfer");

    a_slave_never_busy: assert property (!st_q.mst |=> !st_q.busy)
        else $error("busy set in slave mode");

    a_master_no_count: assert property (st_q.mst |=> st_q.bit_cnt == '0)
        else $error("slave frame counted in master mode");

    a_load_needs_enable: assert property (st_q.load_ok |-> $past(st_q.pen))
        else $error("load accepted while the port was disabled");

    a_disabled_no_count: assert property (!st_q.pen |=> st_q.bit_cnt == '0)
        else $error("disabled port counted link clock edges");

    a_collide_count: assert property (s_colliding_write && slave_act && !sck_rise
        |=> st_q.bit_cnt == $past(st_q.bit_cnt))
        else $error("colliding write disturbed the slave frame count");
endmodule

// ### bench/ssc_far_master.sv
`timescale 1ns/1ps
module ssc_far_master #(
    parameter int unsigned BITS = 8,
    parameter realtime     HALF = 100.0
) (
    // Commands from the bench
    input  wire logic      go,
    input  wire logic      hold_low,
    output logic           busy,
    // Serial pins
    output logic           slave_select_n,
    output logic           sck
);
    // The 7 ns lag keeps pin edges off the bus clock grid
    initial
    begin
        slave_select_n = 1'b1;
        sck = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(go or hold_low);
            #7;
            if (go)
            begin
                busy = 1'b1;
                slave_select_n = 1'b0;
                #HALF;
                repeat (BITS)
                begin
                    sck = 1'b1;
                    #HALF;
                    sck = 1'b0;
                    #HALF;
                end
                slave_select_n = 1'b1;
                busy = 1'b0;
            end
            else
            begin
                slave_select_n = !hold_low;
            end
        end
    end
endmodule

// ### bench/test_spi_status_control.sv
`timescale 1ns/1ps
module test_spi_status_control;
    localparam logic [11:0] CS = ssc_pkg::CS_OFS;
    localparam logic [11:0] IM = ssc_pkg::IMASK_OFS;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        slave_select_n;
    logic        sck;
    logic        eng_dat_wr;
    logic        eng_xfer_done;
    logic        eng_rx_unread;
    logic        eng_load_ok;
    logic        master_enable;
    logic        port_enable;
    logic        port_irq;
    logic        go;
    logic        hold_low;
    logic        frame_busy;
    logic        ok;
    int          errors;
    int          total_checks;

    ssc_top #(.XFER_BITS(8)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .slave_select_n(slave_select_n), .sck(sck), .eng_dat_wr(eng_dat_wr),
        .eng_xfer_done(eng_xfer_done), .eng_rx_unread(eng_rx_unread),
        .eng_load_ok(eng_load_ok), .master_enable(master_enable),
        .port_enable(port_enable), .port_irq(port_irq)
    );

    ssc_far_master #(.BITS(8), .HALF(100.0)) i_far (
        .go(go), .hold_low(hold_low), .busy(frame_busy),
        .slave_select_n(slave_select_n), .sck(sck)
    );

    task automatic report_and_stop();
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready();
        @(posedge hclk);
        for (int n = 0; n < 50 && hreadyout !== 1'b1; n++)
            @(posedge hclk);
        if (hreadyout !== 1'b1)
            errors++;
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= ssc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {20'h00000, a};
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        check(q, exp);
    endtask

    // Load answer is a one-cycle pulse, so it is taken at the very next edge
    task automatic pulse_wr();
        eng_dat_wr <= 1'b1;
        @(posedge hclk);
        eng_dat_wr <= 1'b0;
        @(posedge hclk);
        ok = eng_load_ok;
    endtask

    // A collision lands mid-frame, once the slave count has left zero
    task automatic frame(input logic collide);
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        if (collide)
        begin
            repeat (20) @(posedge hclk);
            pulse_wr();
            check(32'(ok), 32'h00000000);
        end
        for (int n = 0; n < 400 && frame_busy !== 1'b0; n++)
            @(posedge hclk);
        if (frame_busy !== 1'b0)
            errors++;
        repeat (5) @(posedge hclk);
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    initial
    begin
        #(20000 * 25);
        errors++;
        report_and_stop();
    end

    initial
    begin
        errors = 0;
        total_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        eng_dat_wr = 1'b0;
        eng_xfer_done = 1'b0;
        eng_rx_unread = 1'b0;
        go = 1'b0;
        hold_low = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(CS, 32'h00000000);
        rd_chk(IM, 32'h00000000);
        check(32'(port_irq), 32'h00000000);
        wr(12'h008, 32'h000000FF);
        rd_chk(12'h008, 32'h00000000);
        wr(CS, 32'h00000003);
        rd_chk(CS, 32'h00000003);
        check(32'(master_enable), 32'h00000001);
        check(32'(port_enable), 32'h00000001);
        wr(IM, 32'h000000F0);
        rd_chk(IM, 32'h000000F0);
        // Master transfer, then a write that lands while it runs
        pulse_wr();
        check(32'(ok), 32'h00000001);
        rd_chk(CS, 32'h0000000B);
        pulse_wr();
        check(32'(ok), 32'h00000000);
        rd_chk(CS, 32'h0000004B);
        eng_rx_unread <= 1'b1;
        eng_xfer_done <= 1'b1;
        @(posedge hclk);
        eng_xfer_done <= 1'b0;
        repeat (20) @(posedge hclk);
        rd_chk(CS, 32'h000000D3);
        check(32'(port_irq), 32'h00000001);
        wr(IM, 32'h00000000);
        repeat (3) @(posedge hclk);
        check(32'(port_irq), 32'h00000000);
        wr(IM, 32'h000000F0);
        repeat (3) @(posedge hclk);
        check(32'(port_irq), 32'h00000001);
        wr(CS, 32'h000000F3);
        rd_chk(CS, 32'h00000003);
        check(32'(port_irq), 32'h00000000);
        // Select pulled low under master mode
        hold_low <= 1'b1;
        repeat (8) @(posedge hclk);
        rd_chk(CS, 32'h00000027);
        hold_low <= 1'b0;
        repeat (8) @(posedge hclk);
        rd_chk(CS, 32'h00000023);
        wr(CS, 32'h00000023);
        rd_chk(CS, 32'h00000003);
        // Slave frames, with and without unread data
        wr(CS, 32'h00000001);
        frame(1'b0);
        rd_chk(CS, 32'h00000091);
        wr(CS, 32'h000000F1);
        eng_rx_unread <= 1'b0;
        frame(1'b1);
        rd_chk(CS, 32'h000000C1);
        // Disabled port ignores loads and frames
        wr(CS, 32'h000000F0);
        pulse_wr();
        check(32'(ok), 32'h00000000);
        frame(1'b0);
        rd_chk(CS, 32'h00000000);
        check(32'(hresp), 32'h00000000);
        report_and_stop();
    end
endmodule
